// ---- common/flash_irq_regs.vh ----
// Register offsets, field positions and reset values of the flag block
`ifndef FLASH_IRQ_REGS_VH
`define FLASH_IRQ_REGS_VH

// Register offsets (byte addresses)
`define FLAGS_OFS 8'h00
`define MASK_OFS 8'h04
`define CTL_THR_OFS 8'h08
`define RX_THR_OFS 8'h0C
`define TX_THR_OFS 8'h10
`define LEVELS_OFS 8'h14

// Field positions in the flag and mask registers
`define FLAG_WIDTH 12
`define DMA_ERR_BIT 11
`define PKT_DONE_BIT 10
`define DESC_DONE_BIT 9
`define CTL_THR_BIT 8
`define CTL_EMPTY_BIT 7
`define CTL_FULL_BIT 6
`define RX_THR_BIT 5
`define RX_FULL_BIT 4
`define RX_EMPTY_BIT 3
`define TX_THR_BIT 2
`define TX_FULL_BIT 1
`define TX_EMPTY_BIT 0

// Reset values
`define FLAGS_RST 12'h0AD
`define MASK_RST 12'h000
`define THR_RST 8'h00

`endif

// ---- verilog/reset_release.v ----
// Reset synchroniser: asynchronous assert, two-flop release
`timescale 1ns/10ps
module reset_release (
  input wire sys_clk,
  input wire rst_b,
  output wire rst_sync_b
);

  reg meta_q;
  reg hold_q;

  // First flop feeds only the second one
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      hold_q <= meta_q;
    end
  end

  assign rst_sync_b = hold_q;

endmodule

// ---- verilog/space_compare.v ----
// Registered compare of free buffer space against a threshold
`timescale 1ns/10ps
module space_compare #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire rst_sync_b,
  input wire [WIDTH-1:0] free_words,
  input wire [WIDTH-1:0] threshold,
  output reg above_q
);

  // High while more words are free than the threshold
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      above_q <= 1'b0;
    end else begin
      above_q <= (free_words > threshold);
    end
  end

endmodule

// ---- verilog/flash_irq_flags.v ----
// Interrupt status flags of the quad serial memory controller
`timescale 1ns/10ps
`include "flash_irq_regs.vh"
module flash_irq_flags #(
  parameter SPACE_WIDTH = 8
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg irq,
  input wire boot_xip_mode,
  input wire dma_bus_error,
  input wire packet_done,
  input wire descriptor_done,
  input wire control_empty,
  input wire control_full,
  input wire [SPACE_WIDTH-1:0] control_free_words,
  input wire receive_empty,
  input wire receive_full,
  input wire [SPACE_WIDTH-1:0] receive_free_words,
  input wire transmit_empty,
  input wire transmit_full,
  input wire [SPACE_WIDTH-1:0] transmit_free_words
);

  localparam NBUF = 3;

  // One-hot states of the boot hold
  localparam [2:0] BOOT_ARM = 3'b001;
  localparam [2:0] BOOT_HOLD = 3'b010;
  localparam [2:0] BOOT_DONE = 3'b100;

  wire rst_sync_b;
  reg [`FLAG_WIDTH-1:0] flags_q;
  wire [`FLAG_WIDTH-1:0] flags_d;
  reg [`FLAG_WIDTH-1:0] mask_q;
  reg [SPACE_WIDTH-1:0] control_space_threshold_q;
  reg [SPACE_WIDTH-1:0] receive_space_threshold_q;
  reg [SPACE_WIDTH-1:0] transmit_space_threshold_q;
  reg boot_mode_meta_q;
  reg boot_mode_sync_q;
  reg [2:0] boot_state_q;
  reg [2:0] boot_state_d;
  wire boot_hold;
  reg [`FLAG_WIDTH-1:0] set_events;
  reg [`FLAG_WIDTH-1:0] clear_bits;
  reg [31:0] rdata_d;
  wire [NBUF*SPACE_WIDTH-1:0] free_bus;
  wire [NBUF*SPACE_WIDTH-1:0] thr_bus;
  wire [NBUF-1:0] above;
  wire wr_flags;
  wire wr_mask;
  wire wr_ctl_thr;
  wire wr_rx_thr;
  wire wr_tx_thr;

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  reset_release u_reset_release (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .rst_sync_b(rst_sync_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // True when the bus address hits the given register
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Widen a threshold to a read word with zeros above
  function [31:0] thr_word;
    input [SPACE_WIDTH-1:0] thr;
    begin
      thr_word = {{(32-SPACE_WIDTH){1'b0}}, thr};
    end
  endfunction

  // Write enables, one per writable register
  assign wr_flags = reg_wr && hit(reg_addr, `FLAGS_OFS);
  assign wr_mask = reg_wr && hit(reg_addr, `MASK_OFS);
  assign wr_ctl_thr = reg_wr && hit(reg_addr, `CTL_THR_OFS);
  assign wr_rx_thr = reg_wr && hit(reg_addr, `RX_THR_OFS);
  assign wr_tx_thr = reg_wr && hit(reg_addr, `TX_THR_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Free-space comparators, one per buffer

  assign free_bus = {transmit_free_words, receive_free_words,
                     control_free_words};
  assign thr_bus = {transmit_space_threshold_q, receive_space_threshold_q,
                    control_space_threshold_q};

  genvar gi;
  generate
    for (gi = 0; gi < NBUF; gi = gi + 1) begin : g_space
      space_compare #(
        .WIDTH(SPACE_WIDTH)
      ) u_space_compare (
        .sys_clk(sys_clk),
        .rst_sync_b(rst_sync_b),
        .free_words(free_bus[gi*SPACE_WIDTH +: SPACE_WIDTH]),
        .threshold(thr_bus[gi*SPACE_WIDTH +: SPACE_WIDTH]),
        .above_q(above[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Boot/XIP hold of the receive threshold flag

  // Strap pin passes two flops; not reset, so it is valid at release
  always @(posedge sys_clk) begin
    boot_mode_meta_q <= boot_xip_mode;
    boot_mode_sync_q <= boot_mode_meta_q;
  end

  // Sample the strap once after reset; if it is set, hold until the first read
  always @* begin
    boot_state_d = boot_state_q;
    case (boot_state_q)
      BOOT_ARM: begin
        if (boot_mode_sync_q) begin
          boot_state_d = BOOT_HOLD;
        end else begin
          boot_state_d = BOOT_DONE;
        end
      end
      BOOT_HOLD: begin
        if (reg_rd) begin
          boot_state_d = BOOT_DONE;
        end
      end
      BOOT_DONE: begin
        boot_state_d = BOOT_DONE;
      end
      default: begin
        boot_state_d = BOOT_ARM;
      end
    endcase
  end

  // Boot hold state, armed by reset
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      boot_state_q <= BOOT_ARM;
    end else begin
      boot_state_q <= boot_state_d;
    end
  end

  // Flag held from reset until the strap says otherwise or a read comes
  assign boot_hold = (boot_state_q == BOOT_ARM) ||
                     (boot_state_q == BOOT_HOLD);

  ////////////////////////////////////////////////////////////////////////
  // Hardware set sources

  // Each source sets its sticky flag in the cycle it is seen
  always @* begin
    set_events = {`FLAG_WIDTH{1'b0}};
    set_events[`DMA_ERR_BIT] = dma_bus_error;
    set_events[`PKT_DONE_BIT] = packet_done;
    set_events[`DESC_DONE_BIT] = descriptor_done;
    set_events[`CTL_THR_BIT] = above[0];
    set_events[`CTL_EMPTY_BIT] = control_empty;
    set_events[`CTL_FULL_BIT] = control_full;
    set_events[`RX_THR_BIT] = above[1] | boot_hold;
    set_events[`RX_FULL_BIT] = receive_full;
    set_events[`RX_EMPTY_BIT] = receive_empty;
    set_events[`TX_THR_BIT] = above[2];
    set_events[`TX_FULL_BIT] = transmit_full;
    set_events[`TX_EMPTY_BIT] = transmit_empty;
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag register next value

  // Write one clears; only the twelve flag bits are looked at
  always @* begin
    clear_bits = wr_flags ? reg_wdata[`FLAG_WIDTH-1:0] :
                 {`FLAG_WIDTH{1'b0}};
  end

  // Next value of one sticky flag; a set in the same cycle beats a clear
  function sticky_next;
    input q;
    input set;
    input clr;
    begin
      sticky_next = set | (q & ~clr);
    end
  endfunction

  // One sticky cell per flag bit
  genvar fi;
  generate
    for (fi = 0; fi < `FLAG_WIDTH; fi = fi + 1) begin : g_flag
      assign flags_d[fi] = sticky_next(flags_q[fi], set_events[fi],
                                       clear_bits[fi]);
    end
  endgenerate

  // Flag storage with mixed reset values
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      flags_q <= `FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software writable registers

  // Mask and threshold registers
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mask_q <= `MASK_RST;
      control_space_threshold_q <= {SPACE_WIDTH{1'b0}};
      receive_space_threshold_q <= {SPACE_WIDTH{1'b0}};
      transmit_space_threshold_q <= {SPACE_WIDTH{1'b0}};
    end else begin
      if (wr_mask) begin
        mask_q <= reg_wdata[`FLAG_WIDTH-1:0];
      end
      if (wr_ctl_thr) begin
        control_space_threshold_q <= reg_wdata[SPACE_WIDTH-1:0];
      end
      if (wr_rx_thr) begin
        receive_space_threshold_q <= reg_wdata[SPACE_WIDTH-1:0];
      end
      if (wr_tx_thr) begin
        transmit_space_threshold_q <= reg_wdata[SPACE_WIDTH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `FLAGS_OFS: rdata_d = {20'h0_0000, flags_q};
      `MASK_OFS: rdata_d = {20'h0_0000, mask_q};
      `CTL_THR_OFS: rdata_d = thr_word(control_space_threshold_q);
      `RX_THR_OFS: rdata_d = thr_word(receive_space_threshold_q);
      `TX_THR_OFS: rdata_d = thr_word(transmit_space_threshold_q);
      `LEVELS_OFS: rdata_d = {29'h0000_0000, above};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt output

  // Level high while an unmasked flag is set
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_d & mask_q);
    end
  end

endmodule

// ---- dv/flash_irq_flags_chk.sv ----
// Checker of flag register reads, flag setting and clearing
`timescale 1ns/10ps
module flash_irq_flags_chk (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire dma_bus_error,
  input wire packet_done,
  input wire descriptor_done,
  input wire control_empty,
  input wire receive_full,
  input wire transmit_empty
);
  // Accesses to the flag register
  wire rd_f = reg_rd && reg_addr == 8'h00;
  wire wr_f = reg_wr && reg_addr == 8'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Read data and flag setting
  property p_upper; reg_rd |=> reg_rdata[31:12] == 20'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_dma; dma_bus_error ##1 rd_f |=> reg_rdata[11]; endproperty
  a_dma: assert property (p_dma) else $error("dma flag");
  property p_pkt; packet_done ##1 rd_f |=> reg_rdata[10]; endproperty
  a_pkt: assert property (p_pkt) else $error("packet flag");
  property p_desc; descriptor_done ##1 rd_f |=> reg_rdata[9]; endproperty
  a_desc: assert property (p_desc) else $error("descriptor flag");
  property p_cte; control_empty ##1 rd_f |=> reg_rdata[7]; endproperty
  a_cte: assert property (p_cte) else $error("control empty");
  property p_rxf; receive_full ##1 rd_f |=> reg_rdata[4]; endproperty
  a_rxf: assert property (p_rxf) else $error("receive full");
  property p_txe; transmit_empty ##1 rd_f |=> reg_rdata[0]; endproperty
  a_txe: assert property (p_txe) else $error("transmit empty");
  // Write of one clears a flag whose source stays low
  property p_clr;
    (wr_f && reg_wdata[11] && !dma_bus_error) ##1 !dma_bus_error
      ##1 (rd_f && !dma_bus_error) |=> !reg_rdata[11];
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  c_rd: cover property (rd_f ##1 reg_rdata[11]);
  c_wr: cover property (wr_f && reg_wdata[11]);
  c_mask: cover property (reg_rd && reg_addr == 8'h04);
endmodule

// ---- dv/flash_irq_flags_tb.sv ----
// Self-checking bench of the interrupt flag block
`timescale 1ns/10ps
`include "flash_irq_regs.vh"
`define CHK(g, e) begin \
  samples_checked = samples_checked + 1; \
  if ((g) !== (e)) begin \
    error_cnt = error_cnt + 1; \
    $display("unexpected %0t: %h not %h", $time, g, e); \
  end \
end
module flash_irq_flags_tb;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg [11:0] hw = 12'h000;
  reg [7:0] cf = 8'h00, rf = 8'h00, tf = 8'h00;
  reg boot_mode = 1'b1;
  wire [31:0] reg_rdata;
  wire irq;
  integer error_cnt = 0, samples_checked = 0, k;
  ////////////////////////////////////////
  // Clock
  always #5 sys_clk = ~sys_clk;
  // Design with the boot strap driven by the bench
  flash_irq_flags i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .boot_xip_mode(boot_mode),
    .dma_bus_error(hw[11]), .packet_done(hw[10]),
    .descriptor_done(hw[9]), .control_empty(hw[7]),
    .control_full(hw[6]), .control_free_words(cf),
    .receive_empty(hw[3]), .receive_full(hw[4]),
    .receive_free_words(rf), .transmit_empty(hw[0]),
    .transmit_full(hw[1]), .transmit_free_words(tf)
  );
  ////////////////////////////////////////
  // One-cycle register write
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read and compare the data of the following cycle
  task rdc(input [7:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, e)
    end
  endtask
  // Verdict and end of run
  task test_done;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(`FLAGS_OFS, 32'h20);
    rdc(`FLAGS_OFS, 32'h0AD);
    wr(`FLAGS_OFS, 32'hFFFFFFFF);
    rdc(`FLAGS_OFS, 32'h0);
    rdc(8'hFC, 32'h0);
    // Each non-threshold source sets its own flag only
    for (k = 0; k < 12; k = k + 1) begin
      if (k != 2 && k != 5 && k != 8) begin
        @(posedge sys_clk);
        hw[k] <= 1'b1;
        rdc(`FLAGS_OFS, 32'h1 << k);
        @(posedge sys_clk);
        hw[k] <= 1'b0;
        wr(`FLAGS_OFS, 32'h1 << k);
        rdc(`FLAGS_OFS, 32'h0);
      end
    end
    // Interrupt raised, partly cleared, masked, cleared
    wr(`MASK_OFS, 32'h800);
    @(posedge sys_clk);
    hw <= 12'hC00;
    @(posedge sys_clk);
    hw <= 12'h000;
    wr(`FLAGS_OFS, 32'h400);
    rdc(`FLAGS_OFS, 32'h800);
    `CHK(irq, 1'b1)
    wr(`MASK_OFS, 32'h400);
    @(posedge sys_clk);
    #1 `CHK(irq, 1'b0)
    wr(`MASK_OFS, 32'h800);
    wr(`FLAGS_OFS, 32'h800);
    @(posedge sys_clk);
    #1 `CHK(irq, 1'b0)
    // Free space equal to threshold, then one above
    wr(`CTL_THR_OFS, 32'h5);
    wr(`RX_THR_OFS, 32'h7);
    wr(`TX_THR_OFS, 32'h9);
    @(posedge sys_clk);
    cf <= 8'h05;
    rf <= 8'h07;
    tf <= 8'h09;
    repeat (3) @(posedge sys_clk);
    wr(`FLAGS_OFS, 32'hFFF);
    rdc(`FLAGS_OFS, 32'h0);
    @(posedge sys_clk);
    cf <= 8'h06;
    rf <= 8'h08;
    tf <= 8'h0A;
    repeat (3) @(posedge sys_clk);
    rdc(`FLAGS_OFS, 32'h124);
    rdc(`LEVELS_OFS, 32'h7);
    rdc(`RX_THR_OFS, 32'h7);
    // Second reset with boot strap off: threshold flag clears at once
    @(posedge sys_clk);
    rst_b <= 1'b0;
    boot_mode <= 1'b0;
    cf <= 8'h00;
    rf <= 8'h00;
    tf <= 8'h00;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(`FLAGS_OFS, 32'h20);
    rdc(`FLAGS_OFS, 32'h08D);
    test_done;
  end
  // Watchdog against a hang
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule
bind flash_irq_flags flash_irq_flags_chk i_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dma_bus_error(dma_bus_error),
  .packet_done(packet_done), .descriptor_done(descriptor_done),
  .control_empty(control_empty), .receive_full(receive_full),
  .transmit_empty(transmit_empty)
);
